// ===== src/scs_pkg.sv
// Package for the system clock select block: register map, fields, codes.
// Assumes an APB slave with 32-bit data and one word per register.
package scs_pkg;

	// Register byte addresses
	localparam logic [7:0] ADDR_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_STATUS  = 8'h04;
	localparam logic [7:0] ADDR_CONFIG  = 8'h08;
	localparam logic [7:0] ADDR_CURRENT = 8'h0C;

	// Control register fields
	localparam int CTL_PLL_BIT   = 7;
	localparam int CTL_FREQ_HI   = 6;
	localparam int CTL_FREQ_LO   = 3;
	localparam int CTL_SEL_HI    = 1;
	localparam int CTL_SEL_LO    = 0;
	localparam logic [3:0] FREQ_RESET = 4'h7;

	// Status register fields
	localparam int ST_PLL_RDY    = 6;
	localparam int ST_HF_RDY     = 4;
	localparam int ST_LF_RDY     = 1;
	localparam int ST_HF_STABLE  = 0;

	// Clock select codes
	localparam logic [1:0] SEL_CONFIG   = 2'h0;
	localparam logic [1:0] SEL_RESERVED = 2'h1;

	// Configuration source codes
	localparam logic [1:0] SRC_INTERNAL = 2'h0;
	localparam logic [1:0] SRC_EXT_LOW  = 2'h1;
	localparam logic [1:0] SRC_EXT_MED  = 2'h2;
	localparam logic [1:0] SRC_EXT_HIGH = 2'h3;

	// Frequency codes
	localparam logic [3:0] FREQ_16M  = 4'hF;
	localparam logic [3:0] FREQ_8M   = 4'hE;
	localparam logic [3:0] FREQ_4M   = 4'hD;
	localparam logic [3:0] FREQ_2M   = 4'hC;
	localparam logic [3:0] FREQ_1M   = 4'hB;
	localparam logic [3:0] FREQ_500K = 4'hA;
	localparam logic [3:0] FREQ_250K = 4'h9;
	localparam logic [3:0] FREQ_125K = 4'h8;
	localparam logic [3:0] FREQ_500L = 4'h7;
	localparam logic [3:0] FREQ_250L = 4'h6;
	localparam logic [3:0] FREQ_125L = 4'h5;
	localparam logic [3:0] FREQ_62K  = 4'h4;
	localparam logic [3:0] FREQ_31K_HI = 4'h2;

	// Divider ratio log2 from 16 MHz for each high-frequency tap
	localparam logic [3:0] DIV_LOG_16M = 4'h0;
	localparam logic [3:0] DIV_LOG_8M  = 4'h1;
	localparam logic [3:0] DIV_LOG_4M  = 4'h2;
	localparam logic [3:0] DIV_LOG_2M  = 4'h3;
	localparam logic [3:0] DIV_LOG_1M  = 4'h4;
	localparam logic [3:0] DIV_LOG_500K = 4'h5;
	localparam logic [3:0] DIV_LOG_250K = 4'h6;
	localparam logic [3:0] DIV_LOG_125K = 4'h7;
	localparam logic [3:0] DIV_LOG_62K  = 4'h8;
	localparam logic [3:0] DIV_LOG_31K  = 4'h9;

	// Current source codes reported in the current-source register
	localparam logic [2:0] CUR_EXT     = 3'h0;
	localparam logic [2:0] CUR_HF      = 3'h1;
	localparam logic [2:0] CUR_LF      = 3'h2;
	localparam logic [2:0] CUR_PLL     = 3'h3;

	// Switching delays
	localparam int CLK_MHZ          = 125;
	localparam int HF_DELAY_NS      = 2000;
	localparam int HF_DELAY_CYC     = (HF_DELAY_NS * CLK_MHZ) / 1000;
	localparam int POR_DELAY_CYC    = 2;
	localparam int LF_DELAY_CYC     = 2;

	typedef enum logic [1:0] {
		SCS_IDLE  = 2'b00,
		SCS_START = 2'b01,
		SCS_EDGE  = 2'b11
	} scs_state_t;

endpackage

// ===== src/scs_sync.sv
// Two-flop synchroniser for one status level.
// Assumes the input may change at any time relative to clock.
`timescale 1ns/1ps
module scs_sync (
	input  wire logic clock,
	input  wire logic rst_b,
	input  wire logic d,
	output logic      q
);
	logic meta_ff;

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			meta_ff <= 1'b0;
			q       <= 1'b0;
		end else begin
			meta_ff <= d;
			q       <= meta_ff;
		end
	end
endmodule

// ===== src/scs_top.sv
// System clock select and PLL control with APB registers.
// Assumes analog oscillators report ready and stable levels asynchronously,
// and that the clock multiplexer itself is outside, steered by the outputs.
`timescale 1ns/1ps
module scs_top #(
	parameter int HF_DELAY = scs_pkg::HF_DELAY_CYC
) (
	input  wire logic        clock,
	input  wire logic        rst_b,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic [1:0]  cfg_clk_source,
	input  wire logic        pll_ready_raw,
	input  wire logic        hf_osc_ready_raw,
	input  wire logic        lf_osc_ready_raw,
	input  wire logic        hf_osc_stable_raw,
	input  wire logic        cur_clk_level,
	output logic [2:0]       src_sel_ff,
	output logic [3:0]       div_log_ff,
	output logic [1:0]       ext_power_ff,
	output logic             pll_on_ff,
	output logic             hf_en_ff,
	output logic             lf_en_ff,
	output logic             switch_busy_ff
);
	logic        pll_enable_ff;
	logic [3:0]  int_freq_select_ff;
	logic [1:0]  sys_clk_select_ff;
	logic        pll_ready;
	logic        hf_osc_ready;
	logic        lf_osc_ready;
	logic        hf_osc_stable;
	logic        clk_lvl_s;
	logic        clk_lvl_d_ff;
	logic [2:0]  nxt_src;
	logic [3:0]  nxt_div;
	logic        nxt_hf;
	logic [15:0] wait_cnt_ff;
	logic [15:0] nxt_wait;
	logic        por_done_ff;
	logic        cfg_ok_ff;
	logic [2:0]  tgt_src_ff;
	logic [3:0]  tgt_div_ff;
	logic        tgt_hf_ff;
	scs_pkg::scs_state_t state_ff;
	logic        access;
	logic        wr_ctl;
	logic [7:0]  ctl_rd;
	logic [7:0]  st_rd;

	assign access = psel && penable;
	assign wr_ctl = access && pwrite && (paddr == scs_pkg::ADDR_CONTROL);

	// Status detectors and the current clock level cross in from the analog side
	scs_sync u_pll (.clock(clock), .rst_b(rst_b), .d(pll_ready_raw),
		.q(pll_ready));
	scs_sync u_hfr (.clock(clock), .rst_b(rst_b), .d(hf_osc_ready_raw),
		.q(hf_osc_ready));
	scs_sync u_lfr (.clock(clock), .rst_b(rst_b), .d(lf_osc_ready_raw),
		.q(lf_osc_ready));
	scs_sync u_hfs (.clock(clock), .rst_b(rst_b), .d(hf_osc_stable_raw),
		.q(hf_osc_stable));
	scs_sync u_clk (.clock(clock), .rst_b(rst_b), .d(cur_clk_level),
		.q(clk_lvl_s));

	// Control register
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			pll_enable_ff      <= 1'b0;
			int_freq_select_ff <= scs_pkg::FREQ_RESET;
			sys_clk_select_ff  <= scs_pkg::SEL_CONFIG;
		end else if (wr_ctl) begin
			pll_enable_ff      <= pwdata[scs_pkg::CTL_PLL_BIT];
			int_freq_select_ff <=
				pwdata[scs_pkg::CTL_FREQ_HI:scs_pkg::CTL_FREQ_LO];
			// Reserved 01 is kept as written but treated like 00
			sys_clk_select_ff  <=
				pwdata[scs_pkg::CTL_SEL_HI:scs_pkg::CTL_SEL_LO];
		end
	end

	// Configuration source is caught once after reset release
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			cfg_ok_ff    <= 1'b0;
			ext_power_ff <= scs_pkg::SRC_INTERNAL;
		end else if (!cfg_ok_ff) begin
			cfg_ok_ff    <= 1'b1;
			ext_power_ff <= cfg_clk_source;
		end
	end

	// Decode of the target source and divider tap
	always_comb begin
		nxt_src = scs_pkg::CUR_HF;
		nxt_div = scs_pkg::DIV_LOG_500K;
		if (!sys_clk_select_ff[scs_pkg::CTL_SEL_HI] &&
		    ext_power_ff != scs_pkg::SRC_INTERNAL) begin
			nxt_src = scs_pkg::CUR_EXT;
		end else begin
			case (int_freq_select_ff)
			scs_pkg::FREQ_16M:  nxt_div = scs_pkg::DIV_LOG_16M;
			scs_pkg::FREQ_8M:   nxt_div = scs_pkg::DIV_LOG_8M;
			scs_pkg::FREQ_4M:   nxt_div = scs_pkg::DIV_LOG_4M;
			scs_pkg::FREQ_2M:   nxt_div = scs_pkg::DIV_LOG_2M;
			scs_pkg::FREQ_1M:   nxt_div = scs_pkg::DIV_LOG_1M;
			scs_pkg::FREQ_500K,
			scs_pkg::FREQ_500L: nxt_div = scs_pkg::DIV_LOG_500K;
			scs_pkg::FREQ_250K,
			scs_pkg::FREQ_250L: nxt_div = scs_pkg::DIV_LOG_250K;
			scs_pkg::FREQ_125K,
			scs_pkg::FREQ_125L: nxt_div = scs_pkg::DIV_LOG_125K;
			scs_pkg::FREQ_62K:  nxt_div = scs_pkg::DIV_LOG_62K;
			scs_pkg::FREQ_31K_HI,
			4'h3:               nxt_div = scs_pkg::DIV_LOG_31K;
			default: begin
				nxt_src = scs_pkg::CUR_LF;
				nxt_div = scs_pkg::DIV_LOG_16M;
			end
			endcase
			// PLL only on the configured internal path with select 00
			if (!sys_clk_select_ff[scs_pkg::CTL_SEL_HI] && pll_enable_ff &&
			    int_freq_select_ff == scs_pkg::FREQ_8M) begin
				nxt_src = scs_pkg::CUR_PLL;
			end
		end
		nxt_hf = (nxt_src == scs_pkg::CUR_HF) || (nxt_src == scs_pkg::CUR_PLL);
	end

	// Switch sequencer: start-up delay, then a falling edge of the clock
	always_comb begin
		nxt_wait = 16'h0000;
		if (!por_done_ff)
			nxt_wait = 16'(scs_pkg::POR_DELAY_CYC);
		else if (nxt_hf && !hf_en_ff)
			nxt_wait = 16'(HF_DELAY);
		else if (nxt_src == scs_pkg::CUR_LF && nxt_src != src_sel_ff)
			nxt_wait = 16'(scs_pkg::LF_DELAY_CYC);
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			state_ff    <= scs_pkg::SCS_IDLE;
			wait_cnt_ff <= 16'h0000;
			tgt_src_ff  <= scs_pkg::CUR_HF;
			tgt_div_ff  <= scs_pkg::DIV_LOG_500K;
			tgt_hf_ff   <= 1'b1;
			por_done_ff <= 1'b0;
			clk_lvl_d_ff <= 1'b0;
		end else begin
			clk_lvl_d_ff <= clk_lvl_s;
			case (state_ff)
			scs_pkg::SCS_IDLE: begin
				if (cfg_ok_ff && (!por_done_ff || nxt_src != src_sel_ff ||
				    nxt_div != div_log_ff)) begin
					tgt_src_ff  <= nxt_src;
					tgt_div_ff  <= nxt_div;
					tgt_hf_ff   <= nxt_hf;
					wait_cnt_ff <= nxt_wait;
					por_done_ff <= 1'b1;
					state_ff    <= scs_pkg::SCS_START;
				end
			end
			scs_pkg::SCS_START: begin
				if (wait_cnt_ff == 16'h0000)
					state_ff <= scs_pkg::SCS_EDGE;
				else
					wait_cnt_ff <= wait_cnt_ff - 16'h0001;
			end
			scs_pkg::SCS_EDGE: begin
				if (clk_lvl_d_ff && !clk_lvl_s)
					state_ff <= scs_pkg::SCS_IDLE;
			end
			default: state_ff <= scs_pkg::SCS_IDLE;
			endcase
		end
	end

	// Mux steering is updated only when the switch completes
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			src_sel_ff     <= scs_pkg::CUR_HF;
			div_log_ff     <= scs_pkg::DIV_LOG_500K;
			pll_on_ff      <= 1'b0;
			switch_busy_ff <= 1'b1;
		end else begin
			switch_busy_ff <= (state_ff != scs_pkg::SCS_IDLE) ||
				!por_done_ff;
			if (state_ff == scs_pkg::SCS_EDGE && clk_lvl_d_ff && !clk_lvl_s) begin
				src_sel_ff <= tgt_src_ff;
				div_log_ff <= tgt_div_ff;
				pll_on_ff  <= (tgt_src_ff == scs_pkg::CUR_PLL);
			end
		end
	end

	// Oscillator enables: target one starts early, old one stops after
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			hf_en_ff <= 1'b1;
			lf_en_ff <= 1'b0;
		end else if (state_ff == scs_pkg::SCS_START) begin
			hf_en_ff <= hf_en_ff || tgt_hf_ff;
			lf_en_ff <= lf_en_ff || (tgt_src_ff == scs_pkg::CUR_LF);
		end else if (state_ff == scs_pkg::SCS_IDLE) begin
			hf_en_ff <= src_sel_ff == scs_pkg::CUR_HF ||
				src_sel_ff == scs_pkg::CUR_PLL;
			lf_en_ff <= src_sel_ff == scs_pkg::CUR_LF;
		end
	end

	// Read data
	always_comb begin
		ctl_rd = 8'h00;
		ctl_rd[scs_pkg::CTL_PLL_BIT] = pll_enable_ff;
		ctl_rd[scs_pkg::CTL_FREQ_HI:scs_pkg::CTL_FREQ_LO] = int_freq_select_ff;
		ctl_rd[scs_pkg::CTL_SEL_HI:scs_pkg::CTL_SEL_LO] = sys_clk_select_ff;
		st_rd = 8'h00;
		st_rd[scs_pkg::ST_PLL_RDY]   = pll_ready;
		st_rd[scs_pkg::ST_HF_RDY]    = hf_osc_ready;
		st_rd[scs_pkg::ST_LF_RDY]    = lf_osc_ready;
		st_rd[scs_pkg::ST_HF_STABLE] = hf_osc_stable;
	end

	// APB slave: no wait state, pready is high in the first access cycle and read data comes from a flop
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			pready  <= 1'b1;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
			case (paddr)
			scs_pkg::ADDR_CONTROL: prdata <= {24'h000000, ctl_rd};
			scs_pkg::ADDR_STATUS:  prdata <= {24'h000000, st_rd};
			scs_pkg::ADDR_CONFIG:  prdata <= {30'h0, ext_power_ff};
			scs_pkg::ADDR_CURRENT: prdata <= {24'h0, switch_busy_ff,
				div_log_ff, src_sel_ff};
			default: pslverr <= 1'b1;
			endcase
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end
endmodule

// ===== tb/scs_top_monitor.sv
// Checker for the clock select block: APB answers and switch outputs.
// Bound into scs_top; sees only its ports.
`timescale 1ns/1ps
module scs_top_monitor #(
	parameter int HF_DELAY = 4
) (
	input wire logic        clock,
	input wire logic        rst_b,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	input wire logic [2:0]  src_sel_ff,
	input wire logic [3:0]  div_log_ff,
	input wire logic [1:0]  ext_power_ff,
	input wire logic        pll_on_ff,
	input wire logic        lf_en_ff,
	input wire logic        switch_busy_ff
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	wire rd_done = pready && !pwrite;

	AST_ANSWER: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("bus answer not one cycle after setup");
	AST_UNMAPPED: assert property (pready && paddr > 8'h0C |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	AST_CTL_BIT2: assert property (rd_done && paddr == 8'h00 |-> prdata[2] == 1'b0 && prdata[31:8] == 24'h0)
		else $error("control unused bits not zero");
	AST_STAT_ZERO: assert property (rd_done && paddr == 8'h04 |-> (prdata & 32'hFFFFFFAC) == 32'h0)
		else $error("status unused bits not zero");
	AST_PLL_PATH: assert property (pll_on_ff |-> src_sel_ff == 3'h3 && ext_power_ff == 2'h0)
		else $error("pll in use outside its setting");
	AST_EXT_SRC: assert property (src_sel_ff == 3'h0 |-> ext_power_ff != 2'h0)
		else $error("external source with internal config");
	AST_STEADY: assert property (!switch_busy_ff && !$past(switch_busy_ff) |-> $stable(src_sel_ff) && $stable(div_log_ff))
		else $error("output changed outside a switch");
	AST_LF_ON: assert property (src_sel_ff == 3'h2 |-> lf_en_ff)
		else $error("low oscillator selected but off");

	cover property (pll_on_ff);
	cover property (pready && pslverr);
	cover property (src_sel_ff == 3'h2);
endmodule

bind scs_top scs_top_monitor #(.HF_DELAY(HF_DELAY)) u_mon (
	.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata),
	.pslverr(pslverr), .src_sel_ff(src_sel_ff), .div_log_ff(div_log_ff),
	.ext_power_ff(ext_power_ff), .pll_on_ff(pll_on_ff),
	.lf_en_ff(lf_en_ff), .switch_busy_ff(switch_busy_ff));

// ===== tb/scs_top_test.sv
// Self-checking bench for scs_top: APB registers and clock switching.
// Drives every port; the current clock level is a bench toggle every 3 clock cycles.
`timescale 1ns/1ps
module scs_top_test;
	// Long enough that a skipped start-up delay shows in the cycle count
	localparam int HFD = 40;
	logic        clock, rst_b, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        er, cur_clk_level, pll_on_ff, hf_en_ff, lf_en_ff, busy;
	logic [1:0]  cfg_clk_source, ext_power_ff;
	logic [3:0]  raw, div_log_ff;
	logic [2:0]  src_sel_ff;
	int          error_cnt, cmp_count, cyc;

	scs_top #(.HF_DELAY(HFD)) uut (
		.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .cfg_clk_source(cfg_clk_source),
		.pll_ready_raw(raw[3]), .hf_osc_ready_raw(raw[2]),
		.lf_osc_ready_raw(raw[1]), .hf_osc_stable_raw(raw[0]),
		.cur_clk_level(cur_clk_level), .src_sel_ff(src_sel_ff),
		.div_log_ff(div_log_ff), .ext_power_ff(ext_power_ff),
		.pll_on_ff(pll_on_ff), .hf_en_ff(hf_en_ff), .lf_en_ff(lf_en_ff),
		.switch_busy_ff(busy));

	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	// Fast stand-in for the selected clock keeps each switch short
	always begin
		repeat (3) @(posedge clock);
		cur_clk_level <= ~cur_clk_level;
	end

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s: expected %h, seen %h", nm, exp, seen);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) error_cnt++;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Busy may rise a few edges after the write, so give it time first
	task automatic settle();
		repeat (3) @(posedge clock);
		cyc = 3;
		while (busy !== 1'b0 && cyc < 2000) begin
			@(posedge clock);
			cyc++;
		end
		if (busy !== 1'b0) error_cnt++;
	endtask

	// Callers never put the reserved select code 01 in bits 1:0
	task automatic wctl(input logic [31:0] d);
		apb(1'b1, 8'h00, d);
		settle();
	endtask

	task automatic do_reset(input logic [1:0] c);
		@(posedge clock);
		rst_b <= 1'b0;
		cfg_clk_source <= c;
		repeat (6) @(posedge clock);
		rst_b <= 1'b1;
		settle();
	endtask

	// Divider only means something on the high oscillator path
	task automatic chk_out(input logic [2:0] s, input logic [3:0] dv,
		input logic p);
		chk("source", 32'(src_sel_ff), 32'(s));
		if (s == 3'h1) chk("divider", 32'(div_log_ff), 32'(dv));
		chk("pll in use", 32'(pll_on_ff), 32'(p));
	endtask

	task automatic t_reset();
		do_reset(2'h0);
		apb(1'b0, 8'h00, 32'h0);
		chk("control reset", rd, 32'h38);
		chk_out(3'h1, 4'h5, 1'b0);
		$display("reset test done");
	endtask

	task automatic t_status();
		for (int i = 0; i < 16; i++) begin
			raw <= 4'(i);
			repeat (4) @(posedge clock);
			apb(1'b0, 8'h04, 32'h0);
			chk("status", rd, {25'h0, raw[3], 1'b0, raw[2], 2'h0, raw[1:0]});
		end
		apb(1'b1, 8'h04, 32'h0);
		apb(1'b0, 8'h04, 32'h0);
		chk("status write", rd, 32'h53);
		$display("status test done");
	endtask

	task automatic t_regs();
		wctl(32'hFF);
		apb(1'b0, 8'h00, 32'h0);
		chk("control rw", rd, 32'hFB);
		chk_out(3'h1, 4'h0, 1'b0);
		apb(1'b0, 8'h10, 32'h0);
		chk("unmapped", {rd[30:0], er}, 32'h1);
		$display("register test done");
	endtask

	task automatic t_freq();
		for (int c = 15; c >= 0; c--) begin
			wctl(32'(c << 3) | 32'h2);
			if (c >= 4)
				chk_out(3'h1, 4'(c >= 8 ? 15 - c : 12 - c), 1'b0);
			else if (c >= 2)
				chk_out(3'h1, 4'h9, 1'b0);
			else
				chk_out(3'h2, 4'h0, 1'b0);
		end
		chk("hf enable off", 32'(hf_en_ff), 32'h0);
		chk("lf enable on", 32'(lf_en_ff), 32'h1);
		wctl(32'h7A);
		chk("hf start delay", 32'(cyc > HFD), 32'h1);
		chk("hf enable on", 32'(hf_en_ff), 32'h1);
		chk("lf enable off", 32'(lf_en_ff), 32'h0);
		$display("frequency test done");
	endtask

	task automatic t_pll();
		wctl(32'hF0);
		chk_out(3'h3, 4'h0, 1'b1);
		wctl(32'hF2);
		chk_out(3'h1, 4'h1, 1'b0);
		wctl(32'hE8);
		chk_out(3'h1, 4'h2, 1'b0);
		for (int s = 1; s < 4; s++) begin
			do_reset(2'(s));
			chk_out(3'h0, 4'h0, 1'b0);
			chk("power mode", 32'(ext_power_ff), 32'(s));
			apb(1'b0, 8'h08, 32'h0);
			chk("config reg", rd, 32'(s));
		end
		wctl(32'hF0);
		chk_out(3'h0, 4'h0, 1'b0);
		wctl(32'h7A);
		chk_out(3'h1, 4'h0, 1'b0);
		apb(1'b0, 8'h0C, 32'h0);
		chk("current reg", rd, 32'h1);
		$display("pll test done");
	endtask

	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		rst_b = 1'b0;
		{psel, penable, pwrite, cur_clk_level} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		cfg_clk_source = 2'h0;
		raw = 4'hF;
		t_reset();
		t_status();
		t_regs();
		t_freq();
		t_pll();
		end_of_test();
	end

	initial begin
		repeat (60000) @(posedge clock);
		error_cnt++;
		$display("Error watchdog: expected finish, seen hang");
		end_of_test();
	end
endmodule
